//--- common/smc_pkg.sv
// smc_pkg: register map, field positions, reset values and states of the sleep controller.
// assumes a 32-bit APB slave with word-aligned registers.
package smc_pkg;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] SMC_REG_VREG = 12'h0000;
    localparam logic [11:0] SMC_REG_STATUS = 12'h0004;
    localparam logic [11:0] SMC_REG_CTRL = 12'h0008;
    localparam logic [11:0] SMC_REG_PORTHOLD = 12'h000C;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int SMC_VREG_RSVD_BIT = 0;
    localparam int SMC_VREG_LP_BIT = 1;
    localparam logic [1:0] SMC_VREG_RESET = 2'h1;
    localparam int SMC_ST_PD_BIT = 0;
    localparam int SMC_ST_TO_BIT = 1;
    localparam int SMC_ST_ASLEEP_BIT = 2;
    localparam int SMC_ST_NOP_BIT = 3;
    localparam int SMC_ST_WAKE_BIT = 4;
    localparam int SMC_CTRL_WDT_SLEEP_BIT = 0;
    localparam int SMC_CTRL_ADC_RC_BIT = 1;
    localparam int SMC_CTRL_LPBAD_BIT = 2;
    localparam int SMC_CTRL_UNREG_BIT = 3;
    localparam logic [3:0] SMC_CTRL_RESET = 4'h0;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int SMC_CLK_MHZ = 200;
    localparam int SMC_LP_WAKE_US = 2;
    localparam int SMC_LP_WAKE_CYC = SMC_LP_WAKE_US * SMC_CLK_MHZ;

    typedef enum logic [4:0] {
        SMC_RUN = 5'b00001,
        SMC_ENTER = 5'b00010,
        SMC_SLEEP = 5'b00100,
        SMC_STAB = 5'b01000,
        SMC_RESUME = 5'b10000
    } smc_state_e;

    typedef struct packed {
        logic cpu_clk_en;
        logic wdt_clear;
        logic wdt_run;
        logic prescaler_clear;
        logic vreg_low_power;
        logic adc_run;
        logic resume_pulse;
        logic vector_isr;
    } smc_ctrl_s;

endpackage

//--- design/smc_delay.sv
// smc_delay: down-counter giving the wake stabilisation wait.
// assumes start is a single-cycle pulse on pclk.
`timescale 1ns/100ps
module smc_delay #(
    parameter int CYCLES = 400
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    output logic done
);
    logic [15:0] cnt_q;
    logic busy_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 16'h0000;
            busy_q <= 1'b0;
        end else if (start) begin
            cnt_q <= 16'(CYCLES - 1);
            busy_q <= 1'b1;
        end else if (busy_q) begin
            if (cnt_q == 16'h0000) begin
                busy_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - 16'h0001;
            end
        end
    end

    assign done = busy_q && (cnt_q == 16'h0000);
endmodule

//--- design/smc_top.sv
// smc_top: sleep entry, sleep hold and wake sequencing with an APB register file.
// assumes the core pulses sleep_exec once per executed sleep instruction and
// that interrupt flag and enable vectors are on pclk; wake pins are asynchronous.
//
// Contract
// - sleep entered only by sleep instruction
// - watchdog cleared on entry, optionally runs asleep
// - entry clears powerdown, sets timeout flag
// - cpu clock stopped, slow oscillators keep running
// - converter runs asleep on its rc clock
// - pins hold pre-sleep drive state
// - non-watchdog resets unaffected by sleep
// - pin, brownout, power-on resets fully reset
// - watchdog or interrupt wake resumes execution
// - next instruction prefetched during sleep instruction
// - wake needs enable bit, ignores global
// - run next instruction, then vector if global
// - watchdog cleared on every wake
// - pending interrupt before sleep makes no-operation (here only with global clear; if set, full entry then immediate wake)
// - late interrupt: full entry, immediate wake
// - low-power bit puts regulator low asleep
// - low-power wake adds stabilisation delay
// - intolerant peripheral forces normal regulator
// - unregulated variant: lowest power, no delay
// - regulator register: bit1 mode, bit0 reserved one
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module smc_top import smc_pkg::*; #(
    parameter int IRQ_W = 16,
    parameter int PIN_W = 8,
    parameter int LP_WAKE_CYCLES = SMC_LP_WAKE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_exec,
    input wire logic clrwdt_exec,
    input wire logic [IRQ_W-1:0] irq_flags,
    input wire logic [IRQ_W-1:0] irq_enables,
    input wire logic global_irq_enable,
    input wire logic ext_wake_async,
    input wire logic wdt_timeout,
    input wire logic [PIN_W-1:0] pin_out_live,
    input wire logic [PIN_W-1:0] pin_oen_live,
    output logic [PIN_W-1:0] pin_out,
    output logic [PIN_W-1:0] pin_oen,
    output logic prefetch_next,
    output smc_ctrl_s ctrl
);
    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    logic [1:0] vreg_q;
    logic [3:0] cfg_q;
    logic pd_q;
    logic to_q;
    logic nop_q;
    logic wake_q;
    logic wr_en;
    logic rd_en;

    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    // read data is loaded in the setup cycle so it already stands at the access edge
    assign rd_en = psel && !penable && !pwrite;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == SMC_REG_VREG) || (a == SMC_REG_STATUS) ||
                 (a == SMC_REG_CTRL) || (a == SMC_REG_PORTHOLD);
    endfunction

    assign pslverr = psel && penable && !mapped(paddr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vreg_q <= SMC_VREG_RESET;
        end else if (wr_en && paddr == SMC_REG_VREG) begin
            // reserved bit stays set whatever is written
            vreg_q <= {pwdata[SMC_VREG_LP_BIT], 1'b1};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= SMC_CTRL_RESET;
        end else if (wr_en && paddr == SMC_REG_CTRL) begin
            cfg_q <= pwdata[3:0];
        end
    end

    // ----------------------------------------------------------------
    // wake input synchroniser
    // ----------------------------------------------------------------
    logic ext_s1_q;
    logic ext_s2_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_wake_async;
            ext_s2_q <= ext_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // sleep sequencer
    // ----------------------------------------------------------------
    smc_state_e state_q;
    logic irq_pend;
    logic wake_ev;
    logic lp_sel;
    logic lp_used_q;
    logic dly_start;
    logic dly_done;
    logic gie_q;

    // global enable is deliberately absent from the wake term
    assign irq_pend = |(irq_flags & irq_enables);
    assign wake_ev = irq_pend || ext_s2_q || (wdt_timeout && cfg_q[SMC_CTRL_WDT_SLEEP_BIT]);
    // unregulated parts skip the selectable mode and its delay
    assign lp_sel = vreg_q[SMC_VREG_LP_BIT] && !cfg_q[SMC_CTRL_LPBAD_BIT] &&
                    !cfg_q[SMC_CTRL_UNREG_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SMC_RUN;
        end else begin
            case (state_q)
                SMC_RUN: begin
                    // race with pending interrupt is resolved here, at the issue cycle
                    if (sleep_exec && !(irq_pend && !global_irq_enable)) begin
                        state_q <= SMC_ENTER;
                    end
                end
                SMC_ENTER: begin
                    state_q <= SMC_SLEEP;
                end
                SMC_SLEEP: begin
                    if (wake_ev) begin
                        state_q <= lp_used_q ? SMC_STAB : SMC_RESUME;
                    end
                end
                SMC_STAB: begin
                    if (dly_done) begin
                        state_q <= SMC_RESUME;
                    end
                end
                SMC_RESUME: begin
                    state_q <= SMC_RUN;
                end
                default: begin
                    state_q <= SMC_RUN;
                end
            endcase
        end
    end

    assign dly_start = (state_q == SMC_SLEEP) && wake_ev && lp_used_q;

    smc_delay #(
        .CYCLES(LP_WAKE_CYCLES)
    ) u_delay (
        .pclk(pclk),
        .presetn(presetn),
        .start(dly_start),
        .done(dly_done)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lp_used_q <= 1'b0;
        end else if (state_q == SMC_ENTER) begin
            lp_used_q <= lp_sel;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gie_q <= 1'b0;
        end else if (state_q == SMC_SLEEP && wake_ev) begin
            gie_q <= global_irq_enable;
        end
    end

    // ----------------------------------------------------------------
    // status flags; reset values come from the full device reset
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_q <= 1'b1;
            to_q <= 1'b1;
        end else if (state_q == SMC_ENTER) begin
            pd_q <= 1'b0;
            to_q <= 1'b1;
        end else if (clrwdt_exec) begin
            pd_q <= 1'b1;
            to_q <= 1'b1;
        end else if (wdt_timeout && state_q == SMC_RUN) begin
            to_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nop_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            if (state_q == SMC_RUN && sleep_exec) begin
                nop_q <= irq_pend && !global_irq_enable;
            end
            if (state_q == SMC_RESUME) begin
                wake_q <= 1'b1;
            end else if (wr_en && paddr == SMC_REG_STATUS && pwdata[SMC_ST_WAKE_BIT]) begin
                wake_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // pin hold: latch live drive when sleep starts
    // ----------------------------------------------------------------
    logic [PIN_W-1:0] hold_out_q;
    logic [PIN_W-1:0] hold_oen_q;
    logic asleep;
    assign asleep = (state_q == SMC_SLEEP) || (state_q == SMC_STAB);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_out_q <= '0;
            hold_oen_q <= '1;
        end else if (state_q == SMC_RUN && sleep_exec) begin
            hold_out_q <= pin_out_live;
            hold_oen_q <= pin_oen_live;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= '0;
            pin_oen <= '1;
        end else if (asleep || state_q == SMC_ENTER) begin
            pin_out <= hold_out_q;
            pin_oen <= hold_oen_q;
        end else begin
            pin_out <= pin_out_live;
            pin_oen <= pin_oen_live;
        end
    end

    // ----------------------------------------------------------------
    // control outputs
    // ----------------------------------------------------------------
    // oscillators are outside; only the cpu clock is gated here
    assign ctrl.cpu_clk_en = !(asleep || state_q == SMC_ENTER);
    assign ctrl.wdt_clear = (state_q == SMC_ENTER) || (state_q == SMC_RESUME);
    assign ctrl.prescaler_clear = ctrl.wdt_clear;
    assign ctrl.wdt_run = !asleep || cfg_q[SMC_CTRL_WDT_SLEEP_BIT];
    // unregulated parts always sleep at lowest power, but never pay the wake delay
    assign ctrl.vreg_low_power = asleep && (lp_used_q || cfg_q[SMC_CTRL_UNREG_BIT]);
    assign ctrl.adc_run = !asleep || cfg_q[SMC_CTRL_ADC_RC_BIT];
    assign ctrl.resume_pulse = (state_q == SMC_RESUME);
    assign ctrl.vector_isr = (state_q == SMC_RESUME) && gie_q;
    assign prefetch_next = (state_q == SMC_RUN) && sleep_exec;

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            if (paddr == SMC_REG_VREG) begin
                prdata <= {30'h0000_0000, vreg_q};
            end else if (paddr == SMC_REG_STATUS) begin
                prdata <= {27'h000_0000, wake_q, nop_q, asleep, to_q, pd_q};
            end else if (paddr == SMC_REG_CTRL) begin
                prdata <= {28'h000_0000, cfg_q};
            end else if (paddr == SMC_REG_PORTHOLD) begin
                prdata <= 32'(hold_out_q);
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end
endmodule

//--- tb/smc_core_model.sv
// smc_core_model: core pipeline and interrupt sources facing the controller.
// assumes bench requests are one-cycle pulses driven on pclk.
`timescale 1ns/100ps
module smc_core_model #(
    parameter int IRQ_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic do_sleep,
    input wire logic do_clrwdt,
    input wire logic [IRQ_W-1:0] irq_set,
    output logic sleep_exec,
    output logic clrwdt_exec,
    output logic [IRQ_W-1:0] irq_flags
);
    // a stopped core executes nothing, so requests while asleep are lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_exec <= 1'b0;
            clrwdt_exec <= 1'b0;
        end else begin
            sleep_exec <= do_sleep && clk_en;
            clrwdt_exec <= do_clrwdt && clk_en;
        end
    end
    // flags follow their sources whatever the enables say
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flags <= '0;
        end else begin
            irq_flags <= irq_set;
        end
    end
endmodule

//--- tb/smc_top_asserts.sv
// smc_top_asserts: port-level temporal checks of the sleep controller.
// assumes smc_pkg is compiled first; attached to smc_top by bind.
`timescale 1ns/100ps
module smc_top_asserts import smc_pkg::*; #(
    parameter int IRQ_W = 16,
    parameter int PIN_W = 8,
    parameter int LP_WAKE_CYCLES = SMC_LP_WAKE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sleep_exec,
    input wire logic [IRQ_W-1:0] irq_flags,
    input wire logic [IRQ_W-1:0] irq_enables,
    input wire logic global_irq_enable,
    input wire logic [PIN_W-1:0] pin_out,
    input wire logic [PIN_W-1:0] pin_oen,
    input wire logic prefetch_next,
    input wire smc_ctrl_s ctrl
);
    // worst lp wake: enter, sleep, stabilise, resume
    localparam int LP_MAX = LP_WAKE_CYCLES + 4;
    logic pend;
    assign pend = |(irq_flags & irq_enables);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ----------------------------------------------------------------
    // sequences
    // ----------------------------------------------------------------
    sequence s_take;
        sleep_exec && ctrl.cpu_clk_en && !ctrl.resume_pulse;
    endsequence
    sequence s_enter;
        s_take ##0 (global_irq_enable || !pend);
    endsequence
    sequence s_late;
        s_enter ##1 pend;
    endsequence
    AST_ENTRY: assert property (s_enter |=> !ctrl.cpu_clk_en && ctrl.wdt_clear)
        else $error("sleep entry kept clock or skipped watchdog clear");
    AST_NOP: assert property (s_take ##0 (!global_irq_enable && pend) |=> ctrl.cpu_clk_en)
        else $error("pending interrupt did not make sleep a no-operation");
    AST_ONLY_SLEEP: assert property ($fell(ctrl.cpu_clk_en) |-> $past(sleep_exec))
        else $error("clock stopped without sleep instruction");
    AST_PREFETCH: assert property (s_take |-> prefetch_next)
        else $error("no prefetch during sleep instruction");
    AST_PIN_HOLD: assert property (!ctrl.cpu_clk_en && !$past(ctrl.cpu_clk_en)
        |-> $stable(pin_out) && $stable(pin_oen))
        else $error("pin drive changed during sleep");
    AST_WAKE_WDT: assert property (ctrl.resume_pulse |-> ctrl.wdt_clear)
        else $error("wake without watchdog clear");
    AST_VECTOR: assert property (ctrl.vector_isr |-> ctrl.resume_pulse)
        else $error("vector outside a wake");
    AST_LATE: assert property (s_late |-> ##[1:LP_MAX] ctrl.resume_pulse)
        else $error("late interrupt did not wake");
endmodule

bind smc_top smc_top_asserts #(.IRQ_W(IRQ_W), .PIN_W(PIN_W), .LP_WAKE_CYCLES(LP_WAKE_CYCLES))
    chk_u (.pclk, .presetn, .sleep_exec, .irq_flags, .irq_enables, .global_irq_enable,
    .pin_out, .pin_oen, .prefetch_next, .ctrl);

//--- tb/tb_sleep_mode_controller.sv
// tb_sleep_mode_controller: self-checking bench for smc_top.
// assumes smc_pkg, smc_top, the core model and the bound checker are compiled.
`timescale 1ns/100ps
module tb_sleep_mode_controller import smc_pkg::*;;
    localparam int IW = 16;
    localparam int LP = 12;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, sleep_exec, clrwdt_exec, prefetch_next;
    logic global_irq_enable = 0, ext_wake_async = 0, wdt_timeout = 0, req_sleep = 0, req_clr = 0;
    logic [IW-1:0] irq_flags, irq_enables = '0, irq_set = '0, en;
    logic [7:0] pin_out_live = '0, pin_oen_live = '0, pin_out, pin_oen, p;
    logic [3:0] mode [3] = '{4'h3, 4'h4, 4'h8};
    logic lpx [3] = '{1'b1, 1'b0, 1'b1};
    smc_ctrl_s ctrl;
    logic [31:0] exp_q [$];
    int error_cnt = 0, num_checks = 0, n;
    always #2.5 pclk = ~pclk;
    smc_top #(.IRQ_W(IW), .LP_WAKE_CYCLES(LP)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_exec, .clrwdt_exec, .irq_flags,
        .irq_enables, .global_irq_enable, .ext_wake_async, .wdt_timeout, .pin_out_live,
        .pin_oen_live, .pin_out, .pin_oen, .prefetch_next, .ctrl);
    smc_core_model #(.IRQ_W(IW)) core_u (.pclk, .presetn, .clk_en(ctrl.cpu_clk_en),
        .do_sleep(req_sleep), .do_clrwdt(req_clr), .irq_set, .sleep_exec, .clrwdt_exec,
        .irq_flags);
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) exp_q.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // read data is taken at the access edge at which pready is high
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            check("prdata", prdata, exp_q.pop_front());
        end
    end
    task automatic slp(input logic [IW-1:0] late);
        @(posedge pclk);
        req_sleep <= 1'b1;
        @(posedge pclk);
        // the instruction after sleep is a no-operation, so nothing is issued
        req_sleep <= 1'b0;
        if (late != 0) irq_set <= late;
        repeat (3) @(negedge pclk);
    endtask
    task automatic wake();
        @(negedge pclk);
        for (n = 0; n < 100 && ctrl.resume_pulse !== 1'b1; n++) @(negedge pclk);
    endtask
    initial begin
        #100000;
        error_cnt++;
        finish_test();
    end
    initial begin
        void'($urandom(87));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, SMC_REG_VREG, '0, 32'h0000_0001);
        apb(0, SMC_REG_STATUS, '0, 32'h0000_0003);
        apb(0, 12'h010, '0, 32'h0000_0000);
        check("pslverr", err, 1'b1);
        apb(1, SMC_REG_VREG, 32'hFFFF_FFFE, '0);
        apb(0, SMC_REG_VREG, '0, 32'h0000_0003);
        $display("test registers done");
        en = 16'h0001 << ($urandom % IW);
        @(posedge pclk);
        irq_enables <= en;
        global_irq_enable <= 1'b1;
        pin_out_live <= 8'($urandom);
        apb(1, SMC_REG_VREG, '0, '0);
        slp('0);
        check("clk_en", ctrl.cpu_clk_en, 1'b0);
        p = pin_out;
        @(posedge pclk);
        pin_out_live <= ~p;
        pin_oen_live <= 8'hFF;
        irq_set <= ~en;
        repeat (8) @(negedge pclk);
        check("pin_out", pin_out, p);
        check("pin_oen", pin_oen, 8'h00);
        check("asleep", ctrl.cpu_clk_en, 1'b0);
        @(posedge pclk);
        irq_set <= en;
        wake();
        check("vector", ctrl.vector_isr, 1'b1);
        check("fast wake", n < 4, 1'b1);
        apb(0, SMC_REG_STATUS, '0, 32'h0000_0012);
        apb(0, SMC_REG_PORTHOLD, '0, {24'h00_0000, p});
        $display("test interrupt wake done");
        global_irq_enable <= 1'b0;
        req_clr <= 1'b1;
        @(posedge pclk);
        req_clr <= 1'b0;
        apb(1, SMC_REG_STATUS, 32'h0000_0010, '0);
        slp('0);
        check("nop", ctrl.cpu_clk_en, 1'b1);
        apb(0, SMC_REG_STATUS, '0, 32'h0000_000B);
        irq_set <= '0;
        slp(en);
        wake();
        check("vector", ctrl.vector_isr, 1'b0);
        check("late wake", n < 4, 1'b1);
        apb(0, SMC_REG_STATUS, '0, 32'h0000_0012);
        $display("test race done");
        irq_set <= '0;
        apb(1, SMC_REG_VREG, 32'h0000_0003, '0);
        for (int i = 0; i < 3; i++) begin
            apb(1, SMC_REG_CTRL, {28'h000_0000, mode[i]}, '0);
            slp('0);
            check("lp", ctrl.vreg_low_power, lpx[i]);
            check("adc", ctrl.adc_run, mode[i][1]);
            check("wdt run", ctrl.wdt_run, mode[i][0]);
            @(posedge pclk);
            if (i == 0) wdt_timeout <= 1'b1;
            else ext_wake_async <= 1'b1;
            wake();
            check("lp delay", n > LP, i == 0);
            @(posedge pclk);
            wdt_timeout <= 1'b0;
            ext_wake_async <= 1'b0;
        end
        $display("test regulator modes done");
        slp('0);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check("reset wake", ctrl.cpu_clk_en, 1'b1);
        apb(0, SMC_REG_STATUS, '0, 32'h0000_0003);
        repeat (2) @(posedge pclk);
        $display("test reset in sleep done");
        finish_test();
    end
endmodule
